//--- core/ibt_defs.svh
/*
 Register indices, field positions, reset values and timing constants of the indicator blink timer.
 Assumes it is included by its bare name from the indicator timer module.
*/
`ifndef IBT_DEFS_SVH
`define IBT_DEFS_SVH

`define IBT_IDX_PWM_PERIOD   2'h0
`define IBT_IDX_IND_CONTROL  2'h1
`define IBT_IDX_BLINK_TIMING 2'h2
`define IBT_IDX_PRIVACY      2'h3

`define IBT_PWM_CODE_LSB     0
`define IBT_IND_CUR_LSB      0
`define IBT_IND_COUNT_LSB    3
`define IBT_IND_RAMP_LSB     6
`define IBT_BLK_PULSE_LSB    0
`define IBT_BLK_BLANK_LSB    4
`define IBT_PRV_DUTY_LSB     0
`define IBT_PRV_TERM_LSB     3
`define IBT_PRV_LED1_LSB     4
`define IBT_PRV_LED2_LSB     5
`define IBT_PRV_BLINK_LSB    6

`define IBT_RST_PWM_PERIOD   8'h00
`define IBT_RST_IND_CONTROL  8'h00
`define IBT_RST_BLINK_TIMING 8'h00
`define IBT_RST_PRIVACY      8'h00

`define IBT_CLK_PERIOD_NS    5
`define IBT_TICK_US_NS       1000
`define IBT_US_CYCLES        ((`IBT_TICK_US_NS + `IBT_CLK_PERIOD_NS - 1) / `IBT_CLK_PERIOD_NS)
`define IBT_MS_US            1000
`define IBT_RAMP_BASE_MS     12'h04E
`define IBT_PULSE_STEP_MS    12'h020
`define IBT_PULSE_CODE3_MS   12'h05C
`define IBT_PWM_LONG_US      13'h1400
`define IBT_PWM_SHORT_US     13'h0140
`define IBT_PWM_UNIT_US      13'h0200
`define IBT_PWM_UNIT_MIN_US  13'h0020
`define IBT_BLINK_BASE_MS    10'h080

`endif

//--- core/ibt_indicator_timer.sv
/*
 Indicator blink timer: message indicator ramp, hold and blank sequencing and the privacy
 indicator PWM, with its configuration registers behind a simple indexed write/read port.
 Assumes a 200 MHz mclk, synchronous active-high rst and an analog current source that
 performs the actual ramp while indRampUp or indRampDown is high.
*/
// How it works
// - The privacy PWM period is 5.12 ms, 2.56 ms, 1.28 ms or 640 us for codes 0 to 3 and 320 us when the top bit is set.
// - The two ramp bits set both ramp times to 78, 156, 312 or 624 ms.
// - The three current bits give 2.25 mA per step from 2.25 mA up to 18 mA and are passed to the source.
// - A period is two ramp times plus two pulse times, the pulse time being 32 ms per code with 92 ms printed for code 3.
// - The active interval is the period times the period count in bits 5 to 3.
// - The blank interval is the active interval times the blank count in the upper nibble of the blink register.
// - The blink register holds the blank count high and the pulse code low; the control register holds ramp, count and current.
// - Only bits 2 to 0 of the PWM period register act and the rest read as zero.
// - The privacy duty runs from 10 percent at code 0 to 80 percent at code 7 in 10 percent steps.
// - The privacy blink field selects no blink or a 128, 256 or 512 ms blink period.
`timescale 1ns/1ps
`default_nettype none
`include "ibt_defs.svh"
module ibt_indicator_timer
   import ibt_pkg::*;
#(
   parameter int US_CYCLES = `IBT_US_CYCLES,
   parameter int MS_US     = `IBT_MS_US
)
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       regWrEn,
   input  wire logic [1:0] regIdx,
   input  wire logic [7:0] regWrData,
   output logic      [7:0] regRdData,
   input  wire logic       msgModeEn,
   input  wire logic       privModeEn,
   output logic            indSourceOn,
   output logic            indRampUp,
   output logic            indRampDown,
   output logic      [2:0] indCurrentCode,
   output logic            indBlanking,
   output logic            privLed1,
   output logic            privLed2
);
   initial
   begin
      if (US_CYCLES < 1 || MS_US < 1)
         $error("ibt_indicator_timer: divider settings must be positive");
   end

   ibt_tick_if usIf ();
   ibt_tick_if msIf ();

   ibt_tick_div #(.DIV(US_CYCLES)) usDiv
   (
      .mclk (mclk),
      .rst  (rst),
      .en   (1'b1),
      .out  (usIf.src)
   );

   ibt_tick_div #(.DIV(MS_US)) msDiv
   (
      .mclk (mclk),
      .rst  (rst),
      .en   (usIf.tick),
      .out  (msIf.src)
   );

   logic [2:0] pwmPeriod_reg;
   logic [7:0] indControl_reg;
   logic [7:0] blinkTiming_reg;
   logic [7:0] privacy_reg;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         pwmPeriod_reg   <= 3'(`IBT_RST_PWM_PERIOD);
         indControl_reg  <= `IBT_RST_IND_CONTROL;
         blinkTiming_reg <= `IBT_RST_BLINK_TIMING;
         privacy_reg     <= `IBT_RST_PRIVACY;
      end
      else if (regWrEn)
      begin
         case (regIdx)
            `IBT_IDX_PWM_PERIOD:   pwmPeriod_reg   <= regWrData[`IBT_PWM_CODE_LSB +: 3];
            `IBT_IDX_IND_CONTROL:  indControl_reg  <= regWrData;
            `IBT_IDX_BLINK_TIMING: blinkTiming_reg <= regWrData;
            default:               privacy_reg     <= regWrData;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         regRdData <= 8'h00;
      else
      begin
         case (regIdx)
            `IBT_IDX_PWM_PERIOD:   regRdData <= {5'h00, pwmPeriod_reg};
            `IBT_IDX_IND_CONTROL:  regRdData <= indControl_reg;
            `IBT_IDX_BLINK_TIMING: regRdData <= blinkTiming_reg;
            default:               regRdData <= privacy_reg;
         endcase
      end
   end

   logic [1:0]  rampCode;
   logic [2:0]  periodCount;
   logic [2:0]  currentCode;
   logic [3:0]  pulseCode;
   logic [3:0]  blankCount;
   logic [11:0] rampMs;
   logic [11:0] pulseMs;
   logic [11:0] periodMs;
   logic [6:0]  blankTotal;

   assign rampCode    = indControl_reg[`IBT_IND_RAMP_LSB +: 2];
   assign periodCount = indControl_reg[`IBT_IND_COUNT_LSB +: 3];
   assign currentCode = indControl_reg[`IBT_IND_CUR_LSB +: 3];
   assign pulseCode   = blinkTiming_reg[`IBT_BLK_PULSE_LSB +: 4];
   assign blankCount  = blinkTiming_reg[`IBT_BLK_BLANK_LSB +: 4];
   assign rampMs      = `IBT_RAMP_BASE_MS << rampCode;
   // The odd printed figure for code 3 is kept on purpose instead of the linear 96 ms.
   assign pulseMs     = (pulseCode == 4'h3) ? `IBT_PULSE_CODE3_MS
                                            : 12'(`IBT_PULSE_STEP_MS * pulseCode);
   assign periodMs    = 12'((rampMs + pulseMs) << 1);
   // Blanking is counted in whole periods, so no wide multiplier of milliseconds is needed.
   assign blankTotal  = 7'(periodCount * blankCount);

   ibt_state_e  state_reg;
   ibt_state_e  state_next;
   logic [11:0] msCnt_reg;
   logic [2:0]  periodIdx_reg;
   logic [6:0]  blankIdx_reg;
   logic [11:0] target;
   logic        phaseDone;

   always_comb
   begin
      case (state_reg)
         IBT_RAMP_UP:  target = rampMs;
         IBT_RAMP_DN:  target = rampMs;
         IBT_HOLD_ON:  target = pulseMs;
         IBT_HOLD_OFF: target = pulseMs;
         IBT_BLANK:    target = periodMs;
         default:      target = 12'h000;
      endcase
   end

   assign phaseDone = (target == 12'h000) ||
                      (msIf.tick && (msCnt_reg + 12'h001 >= target));

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         IBT_IDLE:
            if (periodCount != 3'h0)
               state_next = IBT_RAMP_UP;
         IBT_RAMP_UP:
            if (phaseDone)
               state_next = IBT_HOLD_ON;
         IBT_HOLD_ON:
            if (phaseDone)
               state_next = IBT_RAMP_DN;
         IBT_RAMP_DN:
            if (phaseDone)
               state_next = IBT_HOLD_OFF;
         IBT_HOLD_OFF:
            if (phaseDone)
            begin
               if (periodIdx_reg + 3'h1 < periodCount)
                  state_next = IBT_RAMP_UP;
               else if (blankTotal != 7'h00)
                  state_next = IBT_BLANK;
               else
                  state_next = IBT_RAMP_UP;
            end
         IBT_BLANK:
            if (phaseDone && blankIdx_reg + 7'h01 >= blankTotal)
               state_next = IBT_RAMP_UP;
         default:
            state_next = IBT_IDLE;
      endcase
      if (!msgModeEn || periodCount == 3'h0)
         state_next = IBT_IDLE;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state_reg     <= IBT_IDLE;
         msCnt_reg     <= 12'h000;
         periodIdx_reg <= 3'h0;
         blankIdx_reg  <= 7'h00;
      end
      else
      begin
         state_reg <= state_next;
         if (state_next != state_reg || (state_reg == IBT_BLANK && phaseDone))
            msCnt_reg <= 12'h000;
         else if (msIf.tick)
            msCnt_reg <= msCnt_reg + 12'h001;
         if (state_next == IBT_IDLE || state_reg == IBT_BLANK)
            periodIdx_reg <= 3'h0;
         else if (state_reg == IBT_HOLD_OFF && phaseDone)
            periodIdx_reg <= (state_next == IBT_RAMP_UP && periodIdx_reg + 3'h1 < periodCount)
                             ? periodIdx_reg + 3'h1 : 3'h0;
         if (state_reg != IBT_BLANK)
            blankIdx_reg <= 7'h00;
         else if (phaseDone)
            blankIdx_reg <= blankIdx_reg + 7'h01;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         indSourceOn    <= 1'b0;
         indRampUp      <= 1'b0;
         indRampDown    <= 1'b0;
         indCurrentCode <= 3'h0;
         indBlanking    <= 1'b0;
      end
      else
      begin
         indSourceOn    <= (state_reg == IBT_RAMP_UP) || (state_reg == IBT_HOLD_ON) ||
                           (state_reg == IBT_RAMP_DN);
         indRampUp      <= (state_reg == IBT_RAMP_UP);
         indRampDown    <= (state_reg == IBT_RAMP_DN);
         indCurrentCode <= currentCode;
         indBlanking    <= (state_reg == IBT_BLANK);
      end
   end

   logic [12:0] pwmPeriodUs;
   logic [12:0] pwmUnitUs;
   logic [12:0] pwmOnUs;
   logic [2:0]  dutyCode;
   logic [1:0]  blinkCode;
   logic [9:0]  blinkHalfMs;
   logic [12:0] usCnt_reg;
   logic [9:0]  blinkCnt_reg;
   logic        blinkGate_reg;

   // A set top bit overrides the low bits, so codes 4 to 7 all give the shortest period.
   assign pwmPeriodUs = pwmPeriod_reg[2] ? `IBT_PWM_SHORT_US
                                         : (`IBT_PWM_LONG_US >> pwmPeriod_reg[1:0]);
   assign pwmUnitUs   = pwmPeriod_reg[2] ? `IBT_PWM_UNIT_MIN_US
                                         : (`IBT_PWM_UNIT_US >> pwmPeriod_reg[1:0]);
   assign dutyCode    = privacy_reg[`IBT_PRV_DUTY_LSB +: 3];
   assign pwmOnUs     = 13'(pwmUnitUs * ({1'b0, dutyCode} + 4'h1));
   assign blinkCode   = privacy_reg[`IBT_PRV_BLINK_LSB +: 2];
   assign blinkHalfMs = (`IBT_BLINK_BASE_MS >> 2) << blinkCode;

   always_ff @(posedge mclk)
   begin
      if (rst || !privModeEn)
         usCnt_reg <= 13'h0000;
      else if (usIf.tick)
         usCnt_reg <= (usCnt_reg + 13'h0001 >= pwmPeriodUs) ? 13'h0000
                                                          : usCnt_reg + 13'h0001;
   end

   // The blink is taken as an even on/off split of the selected blink period.
   always_ff @(posedge mclk)
   begin
      if (rst || !privModeEn || blinkCode == 2'h0)
      begin
         blinkCnt_reg  <= 10'h000;
         blinkGate_reg <= 1'b1;
      end
      else if (msIf.tick)
      begin
         if (blinkCnt_reg + 10'h001 >= blinkHalfMs)
         begin
            blinkCnt_reg  <= 10'h000;
            blinkGate_reg <= !blinkGate_reg;
         end
         else
            blinkCnt_reg <= blinkCnt_reg + 10'h001;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         privLed1 <= 1'b0;
         privLed2 <= 1'b0;
      end
      else
      begin
         privLed1 <= privModeEn && blinkGate_reg && (usCnt_reg < pwmOnUs) &&
                     privacy_reg[`IBT_PRV_LED1_LSB];
         privLed2 <= privModeEn && blinkGate_reg && (usCnt_reg < pwmOnUs) &&
                     privacy_reg[`IBT_PRV_LED2_LSB];
      end
   end
endmodule // ibt_indicator_timer
`default_nettype wire

//--- core/ibt_pkg.sv
/*
 Types shared by the indicator blink timer modules.
 Assumes nothing beyond the constants header.
*/
package ibt_pkg;
   typedef enum logic [2:0]
   {
      IBT_IDLE     = 3'b000,
      IBT_RAMP_UP  = 3'b001,
      IBT_HOLD_ON  = 3'b010,
      IBT_RAMP_DN  = 3'b011,
      IBT_HOLD_OFF = 3'b100,
      IBT_BLANK    = 3'b101
   } ibt_state_e;
endpackage

//--- core/ibt_tick_div.sv
/*
 Enable divider: one pulse on tick for every DIV cycles in which en is high.
 Assumes a synchronous active-high reset and one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ibt_tick_div
   import ibt_pkg::*;
#(
   parameter int DIV = 200
)
(
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic en,
   ibt_tick_if.src   out
);
   initial
   begin
      if (DIV < 1 || DIV > 65535)
         $error("ibt_tick_div: DIV out of range");
   end

   logic [15:0] count_reg;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         count_reg <= 16'h0000;
         out.tick  <= 1'b0;
      end
      else if (en && count_reg == 16'(DIV - 1))
      begin
         count_reg <= 16'h0000;
         out.tick  <= 1'b1;
      end
      else
      begin
         if (en)
            count_reg <= count_reg + 16'h0001;
         out.tick <= 1'b0;
      end
   end
endmodule // ibt_tick_div
`default_nettype wire

//--- core/ibt_tick_if.sv
/*
 Carries one timing enable pulse from a divider to its users.
 Assumes a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface ibt_tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input tick);
endinterface
`default_nettype wire

//--- verification/ibt_led_model.sv
/*
 Indicator LED fed by the programmable current source.
 Assumes the source follows indSourceOn and indCurrentCode one cycle late.
*/
`timescale 1ns/1ps
`default_nettype none
module ibt_led_model
(
   input  wire logic       mclk,
   input  wire logic       indSourceOn,
   input  wire logic [2:0] indCurrentCode,
   output logic      [6:0] ledQuarterMa
);
   // Current is kept in quarter milliamps so that the 2.25 mA step stays exact.
   always_ff @(posedge mclk)
   begin
      ledQuarterMa <= indSourceOn ? 7'(({4'h0, indCurrentCode} + 7'h01) * 7'h09) : 7'h00;
   end
endmodule // ibt_led_model
`default_nettype wire

//--- verification/ibt_timer_assertions.sv
/*
 Port assertions and covers for the indicator blink timer.
 Assumes it is bound onto ibt_indicator_timer with the same timing parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module ibt_timer_assertions
#(
   parameter int US_CYCLES = 200,
   parameter int MS_US     = 1000
)
(
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic       regWrEn,
   input wire logic [1:0] regIdx,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regRdData,
   input wire logic       msgModeEn,
   input wire logic       privModeEn,
   input wire logic       indSourceOn,
   input wire logic       indRampUp,
   input wire logic       indRampDown,
   input wire logic [2:0] indCurrentCode,
   input wire logic       indBlanking,
   input wire logic       privLed1,
   input wire logic       privLed2
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   int upCnt;
   // A counter is used because the longest ramp is far beyond any repetition count.
   always_ff @(posedge mclk)
   begin
      upCnt <= (rst || !indRampUp) ? 0 : upCnt + 1;
   end
   a_ramp_excl: assert property (!(indRampUp && indRampDown)) else $error("both ramps");
   a_ramp_bound: assert property (indRampUp |-> upCnt < 624 * US_CYCLES * MS_US + 2)
      else $error("ramp up too long");
   a_ramp_source: assert property ((indRampUp || indRampDown) |-> indSourceOn)
      else $error("ramp without source");
   a_down_after_on: assert property ($rose(indRampDown) |-> $past(indSourceOn))
      else $error("ramp down from dark");
   a_blank_dark: assert property (indBlanking |-> !indSourceOn)
      else $error("source on while blank");
   a_mode_off: assert property (!msgModeEn |-> ##2 (!indSourceOn && !indBlanking))
      else $error("sequence runs with mode off");
   a_pwm_mask: assert property (regIdx == 2'h0 |=> regRdData[7:3] == 5'h00)
      else $error("unused period bits read back");
   a_rd_after_wr: assert property ((regWrEn && regIdx != 2'h0) ##1 regIdx == $past(regIdx)
      |=> regRdData == $past(regWrData, 2)) else $error("read back differs");
   a_cur_code: assert property ((regWrEn && regIdx == 2'h1) ##1 !regWrEn [*2]
      |=> indCurrentCode == $past(regWrData[2:0], 3)) else $error("current code stale");
   a_priv_off: assert property (!privModeEn [*3] |-> !(privLed1 || privLed2))
      else $error("privacy led on while off");
   c_blank_end: cover property ($fell(indBlanking));
   c_ramp_end: cover property ($fell(indRampDown));
   c_priv_on: cover property ($rose(privLed1));
endmodule // ibt_timer_assertions
bind ibt_indicator_timer ibt_timer_assertions #(.US_CYCLES(US_CYCLES), .MS_US(MS_US)) i_chk
(
   .mclk, .rst, .regWrEn, .regIdx, .regWrData, .regRdData, .msgModeEn, .privModeEn,
   .indSourceOn, .indRampUp, .indRampDown, .indCurrentCode, .indBlanking, .privLed1, .privLed2
);
`default_nettype wire

//--- verification/tb.sv
/*
 Self-checking testbench of the indicator blink timer with an LED model.
 Assumes shortened timing: 2 cycles per microsecond, 4 microseconds per millisecond tick.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct {string name; logic [31:0] val;} ibt_note_s;
   logic        mclk, rst, regWrEn, msgModeEn, privModeEn, indSourceOn, indRampUp;
   logic        indRampDown, indBlanking, privLed1, privLed2;
   logic [1:0]  regIdx;
   logic [2:0]  indCurrentCode;
   logic [6:0]  ledQuarterMa;
   logic [7:0]  regWrData, regRdData;
   logic [31:0] seenVal;
   int          bad_count, comparisons, seed, n, h, per, d;
   int          codes[6] = '{0, 1, 2, 3, 4, 7};
   ibt_note_s   expQ[$];
   event        seenEv;
   ibt_indicator_timer #(.US_CYCLES(2), .MS_US(4)) i_dut
   (
      .mclk, .rst, .regWrEn, .regIdx, .regWrData, .regRdData, .msgModeEn, .privModeEn,
      .indSourceOn, .indRampUp, .indRampDown, .indCurrentCode, .indBlanking, .privLed1, .privLed2
   );
   ibt_led_model i_led (.mclk, .indSourceOn, .indCurrentCode, .ledQuarterMa);
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   task automatic check(string s, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %0h seen %0h", s, exp, seen);
      end
   endtask
   task automatic note(string s, logic [31:0] v);
      expQ.push_back('{s, v});
   endtask
   task automatic post(logic [31:0] v);
      seenVal = v;
      -> seenEv;
      @(negedge mclk);
   endtask
   task automatic wr(logic [1:0] idx, logic [7:0] dat);
      regIdx = idx;
      regWrData = dat;
      regWrEn = 1'b1;
      @(negedge mclk);
      regWrEn = 1'b0;
      @(negedge mclk);
   endtask
   task automatic rd(logic [1:0] idx, logic [7:0] exp, string s);
      regIdx = idx;
      note(s, {24'h000000, exp});
      repeat (2) @(negedge mclk);
      post({24'h000000, regRdData});
   endtask
   function automatic logic sig(int s);
      case (s)
         0: return indRampDown;
         1: return indSourceOn && !indRampUp && !indRampDown;
         2: return indBlanking;
         3: return privLed1;
         default: return privLed2;
      endcase
   endfunction
   // A fresh span skips any partial phase so only whole phases are timed.
   task automatic span(int s, logic lvl, output int cnt, input bit fresh);
      if (fresh)
      begin
         while (sig(s) == lvl) @(negedge mclk);
         while (sig(s) != lvl) @(negedge mclk);
      end
      cnt = 0;
      while (sig(s) == lvl)
      begin
         cnt++;
         @(negedge mclk);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      ibt_note_s e;
      forever
      begin
         @(seenEv);
         e = expQ.pop_front();
         check(e.name, seenVal, e.val);
      end
   end
   initial
   begin
      repeat (95000) @(posedge mclk);
      bad_count++;
      print_verdict();
   end
   initial
   begin
      seed = 32'h2f0b;
      {rst, regWrEn, msgModeEn, privModeEn, regIdx, regWrData} = {4'h8, 2'h0, 8'h00};
      repeat (12) @(negedge mclk);
      rst = 1'b0;
      for (int i = 0; i < 4; i++) rd(i[1:0], 8'h00, "reset value");
      for (int i = 0; i < 4; i++)
      begin
         n = $random(seed);
         wr(i[1:0], n[7:0]);
         rd(i[1:0], (i == 0) ? {5'h00, n[2:0]} : n[7:0], "read back");
      end
      $display("test registers done");
      wr(2'h1, 8'h00);
      msgModeEn = 1'b1;
      repeat (50) @(negedge mclk);
      note("count zero idle", 0);
      post({31'h0, indSourceOn});
      msgModeEn = 1'b0;
      wr(2'h2, 8'h13);
      wr(2'h1, 8'h12);
      msgModeEn = 1'b1;
      note("hold ms", 92);
      note("led current", 27);
      note("ramp down ms", 78);
      note("blank ms", 680);
      span(1, 1'b1, n, 1'b1);
      post((n + 4) / 8);
      post({25'h0, ledQuarterMa});
      span(0, 1'b1, n, 1'b0);
      post((n + 4) / 8);
      span(2, 1'b1, n, 1'b1);
      post((n + 4) / 8);
      msgModeEn = 1'b0;
      $display("test hold and blank done");
      wr(2'h2, 8'h00);
      for (int r = 0; r < 4; r++)
      begin
         wr(2'h1, {r[1:0], 3'b001, r[2:0]});
         msgModeEn = 1'b1;
         note("ramp ms", 78 << r);
         span(0, 1'b1, n, 1'b1);
         post((n + 4) / 8);
         msgModeEn = 1'b0;
         repeat (3) @(negedge mclk);
         note("mode off dark", 0);
         post({31'h0, indSourceOn});
      end
      $display("test ramp codes done");
      privModeEn = 1'b1;
      foreach (codes[k])
      begin
         d = $random(seed) & 7;
         wr(2'h3, 8'h10 | d[7:0]);
         wr(2'h0, codes[k][7:0]);
         per = (codes[k] > 3) ? 320 : (5120 >> codes[k]);
         note("pwm high us", per / 10 * (d + 1));
         note("pwm period us", per);
         span(3, 1'b1, h, 1'b1);
         span(3, 1'b0, n, 1'b0);
         post((h + 1) / 2);
         post((h + n + 1) / 2);
      end
      // Restarting the mode aligns the blink gate with the PWM window, so whole halves are seen.
      for (int b = 1; b < 4; b += 2)
      begin
         privModeEn = 1'b0;
         wr(2'h3, {b[1:0], 6'h17});
         wr(2'h0, 8'h00);
         privModeEn = 1'b1;
         note("blink off ms", (128 << (b - 1)) / 2);
         note("blink on ms", (128 << (b - 1)) / 2);
         span(3, 1'b1, h, 1'b1);
         span(3, 1'b0, n, 1'b0);
         span(3, 1'b1, h, 1'b0);
         post((n + 4) / 8);
         post((h + 4) / 8);
      end
      wr(2'h3, 8'h23);
      wr(2'h0, 8'h07);
      note("led2 high us", 320 / 10 * 4);
      note("led1 gated", 0);
      span(4, 1'b1, h, 1'b1);
      post((h + 1) / 2);
      post({31'h0, privLed1});
      privModeEn = 1'b0;
      $display("test privacy pwm done");
      print_verdict();
   end
endmodule // tb
`default_nettype wire
